// [verilog/acr_pkg.sv]
// shared constants for the converter clock and rate control block
package acr_pkg;
   // system clock
   localparam int CLK_PERIOD_NS   = 8;
   // external clock is taken as present while its period stays under 5000 ns (200 kHz)
   localparam int EXT_DET_PERIOD_NS = 5000;
   localparam int DET_CYCLES      = EXT_DET_PERIOD_NS / CLK_PERIOD_NS;
   localparam int DET_W           = 10;
   // internal oscillator: clk divided down to roughly 4.9152 MHz
   localparam int OSC_DIV         = 25;
   localparam int OSC_W           = 5;
   // active clocks per modulator sample (4.9152 MHz / 76.8 kHz)
   localparam int MOD_DIV         = 64;
   localparam int MOD_W           = 6;
   // active clocks per result for each rate-select level
   localparam int RATIO_SLOW      = 491520;
   localparam int RATIO_FAST      = 61440;
   localparam int CONV_W          = 19;
   // results until a step is fully settled (fifth one is clean)
   localparam int SETTLE_RESULTS  = 5;
   localparam int SETTLE_W        = 3;
   // decimation filter
   localparam int FILT_ORDER      = 4;
   localparam int ACC_W           = 56;
   localparam int CODE_W          = 20;
   localparam int SHIFT_SLOW      = 33;
   localparam int SHIFT_FAST      = 21;
   localparam logic [CODE_W-1:0] CODE_MAX = 20'h7_FFFF;
   localparam logic [CODE_W-1:0] CODE_MIN = 20'h8_0000;
endpackage

// [verilog/acr_sinc_filter.sv]
// fourth-order sinc decimation filter for the modulator bit stream
`timescale 1ns/1ps
module acr_sinc_filter
   import acr_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              clear,
   input  wire logic              sample_en,
   input  wire logic              sample_bit,
   input  wire logic              dump,
   input  wire logic              fast,
   output logic [CODE_W-1:0]      code,
   output logic                   code_valid
);
   logic signed [ACC_W-1:0] integ [FILT_ORDER];
   logic signed [ACC_W-1:0] zdly  [FILT_ORDER];
   logic signed [ACC_W-1:0] comb  [FILT_ORDER+1];
   logic signed [ACC_W-1:0] scaled;
   logic signed [ACC_W-1:0] in_val;

   // bit 1 weighs +1, bit 0 weighs -1
   assign in_val = sample_bit ? ACC_W'(1) : -ACC_W'(1);

   // integrator chain runs at the modulator rate
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < FILT_ORDER; i++) integ[i] <= '0;
      end else if (clear) begin
         for (int i = 0; i < FILT_ORDER; i++) integ[i] <= '0;
      end else if (sample_en) begin // R06
         integ[0] <= integ[0] + in_val;
         for (int i = 1; i < FILT_ORDER; i++) integ[i] <= integ[i] + integ[i-1];
      end
   end

   // comb chain evaluated at the conversion boundary
   always_comb begin
      comb[0] = integ[FILT_ORDER-1];
      for (int i = 0; i < FILT_ORDER; i++) comb[i+1] = comb[i] - zdly[i];
      scaled = fast ? (comb[FILT_ORDER] >>> SHIFT_FAST) : (comb[FILT_ORDER] >>> SHIFT_SLOW);
   end

   // comb delays and clipped result word
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < FILT_ORDER; i++) zdly[i] <= '0;
         code       <= '0;
         code_valid <= 1'b0;
      end else if (clear) begin
         for (int i = 0; i < FILT_ORDER; i++) zdly[i] <= '0;
         code       <= '0;
         code_valid <= 1'b0;
      end else begin
         code_valid <= dump;
         if (dump) begin
            for (int i = 0; i < FILT_ORDER; i++) zdly[i] <= comb[i];
            // two's complement with clipping; a positive-only input stream gives codes >= 0
            if (scaled > $signed({{(ACC_W-CODE_W){1'b0}}, CODE_MAX}))
               code <= CODE_MAX; // R09
            else if (scaled < $signed({{(ACC_W-CODE_W){1'b1}}, CODE_MIN}))
               code <= CODE_MIN;
            else
               code <= scaled[CODE_W-1:0];
         end
      end
   end

   valid_follows_dump_a: assert property (@(posedge clk) disable iff (!rstn)
      dump && !clear |=> code_valid) // R06
      else $error("result not presented after boundary");
endmodule

// [verilog/acr_rate_ctrl.sv]
// clock source selection, result rate timing and settling tracking
//
// Overview of operation
// [R01] fast external clock: detector low, use it
// [R02] slow or absent external clock: internal oscillator
// [R03] unused external clock pin tied to ground
// [R04] rate-select low: result every 491,520 clocks
// [R05] rate-select high: result every 61,440 clocks
// [R06] sinc4 filter fed at 76.8 kHz
// [R07] all rates follow the active clock only
// [R08] host discards first four results after step
// [R09] single-ended positive input gives non-negative codes
// [R10] configuration only from static pins
// [R11] power-down holds conversion logic in reset
// [R12] external clock nominal 4.9152 MHz, low selects oscillator
// [R13] count from zero, result at chosen ratio
// [R14] rate change applies at boundary, restarts settling
`timescale 1ns/1ps
module acr_rate_ctrl
   import acr_pkg::*;
#(
   parameter int RATIO_SLOW_P = RATIO_SLOW,
   parameter int RATIO_FAST_P = RATIO_FAST
)(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              ext_clock_in,
   input  wire logic              power_down_n,
   input  wire logic              rate_sel,
   input  wire logic              mod_bit,
   output logic                   clk_detect,
   output logic                   osc_enable,
   output logic                   active_tick,
   output logic                   mod_tick,
   output logic [CODE_W-1:0]      result_code,
   output logic                   result_valid,
   output logic                   result_settled
);
   logic              ext_q;
   logic              ext_rise;
   logic [DET_W-1:0]  gap_cnt;
   logic [OSC_W-1:0]  osc_cnt;
   logic              osc_tick;
   logic [MOD_W-1:0]  mod_cnt;
   logic [CONV_W-1:0] conv_cnt;
   logic [CONV_W-1:0] ratio_last;
   logic              rate_q;
   logic              boundary;
   logic [SETTLE_W-1:0] settle_cnt;
   logic              run;

   localparam logic [CONV_W-1:0] LAST_SLOW = CONV_W'(RATIO_SLOW_P - 1);
   localparam logic [CONV_W-1:0] LAST_FAST = CONV_W'(RATIO_FAST_P - 1);
   localparam logic [DET_W-1:0]  DET_LAST  = DET_W'(DET_CYCLES);

   // conversion logic only runs while power-down is released
   assign run = power_down_n; // R11

   // external clock edge, pin is synchronous to clk
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) ext_q <= 1'b0;
      else       ext_q <= ext_clock_in;
   end
   assign ext_rise = ext_clock_in && !ext_q;

   // clock presence detector: a gap longer than one 200 kHz period means absent
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gap_cnt    <= DET_LAST;
         clk_detect <= 1'b1;
      end else if (ext_rise) begin
         gap_cnt    <= '0;
         clk_detect <= 1'b0; // R01
      end else if (gap_cnt == DET_LAST) begin
         clk_detect <= 1'b1; // R02 R12
      end else begin
         gap_cnt    <= gap_cnt + DET_W'(1);
      end
   end

   // oscillator runs only while no external clock is seen
   assign osc_enable = clk_detect; // R01 R02

   // internal oscillator model, stopped when disabled or powered down
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)                     osc_cnt <= '0;
      else if (!osc_enable || !run)  osc_cnt <= '0;
      else if (osc_tick)             osc_cnt <= '0;
      else                           osc_cnt <= osc_cnt + OSC_W'(1);
   end
   assign osc_tick = osc_enable && run && (osc_cnt == OSC_W'(OSC_DIV - 1));

   // one active clock period from whichever source is selected
   assign active_tick = run && (clk_detect ? osc_tick : ext_rise); // R01 R02 R07

   // modulator sample strobe every 64 active clocks
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)            mod_cnt <= '0;
      else if (!run)        mod_cnt <= '0;
      else if (active_tick) mod_cnt <= mod_cnt + MOD_W'(1); // R06 R07
   end
   assign mod_tick = active_tick && (mod_cnt == MOD_W'(MOD_DIV - 1));

   // rate pin sampled at boundaries and while in power-down, no other rate setting exists
   assign ratio_last = rate_q ? LAST_FAST : LAST_SLOW; // R10
   assign boundary   = active_tick && (conv_cnt == ratio_last);

   // conversion counter counts active clocks from zero after power-up
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)            conv_cnt <= '0;
      else if (!run)        conv_cnt <= '0; // R13
      else if (boundary)    conv_cnt <= '0; // R04 R05
      else if (active_tick) conv_cnt <= conv_cnt + CONV_W'(1); // R13
   end

   // rate latch follows the pin at each boundary and while held in power-down
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)         rate_q <= 1'b0;
      else if (!run)     rate_q <= rate_sel;
      else if (boundary) rate_q <= rate_sel; // R14
   end

   // settling tracker: results counted since start or last rate change
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         settle_cnt     <= '0;
         result_settled <= 1'b0;
      end else if (!run) begin
         settle_cnt     <= '0;
         result_settled <= 1'b0;
      end else if (boundary) begin
         result_settled <= (settle_cnt >= SETTLE_W'(SETTLE_RESULTS - 1)); // R08
         if (rate_sel != rate_q)
            settle_cnt <= '0; // R14
         else if (settle_cnt < SETTLE_W'(SETTLE_RESULTS))
            settle_cnt <= settle_cnt + SETTLE_W'(1);
      end
   end

   // decimation filter, dumped at every conversion boundary
   acr_sinc_filter u_filt (
      .clk        (clk),
      .rstn       (rstn),
      .clear      (!run),
      .sample_en  (mod_tick),
      .sample_bit (mod_bit),
      .dump       (boundary),
      .fast       (rate_q),
      .code       (result_code),
      .code_valid (result_valid)
   );

   // helper: active clocks seen since last boundary
   logic [CONV_W:0] tick_seen;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)            tick_seen <= '0;
      else if (!run)        tick_seen <= '0;
      else if (boundary)    tick_seen <= '0;
      else if (active_tick) tick_seen <= tick_seen + (CONV_W+1)'(1);
   end

   // helper: active clocks since the last modulator strobe, kept apart from mod_cnt
   logic [MOD_W:0] mod_gap;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)            mod_gap <= '0;
      else if (!run)        mod_gap <= '0;
      else if (mod_tick)    mod_gap <= '0;
      else if (active_tick) mod_gap <= mod_gap + (MOD_W+1)'(1);
   end

   sequence ext_edge_s;
      ext_clock_in && !ext_q;
   endsequence

   sequence gap_full_s;
      !ext_rise && gap_cnt == DET_LAST;
   endsequence

   sequence rate_flip_s;
      boundary && rate_sel != rate_q;
   endsequence

   ext_detect_low_a: assert property (@(posedge clk) disable iff (!rstn) // R01
      ext_edge_s |=> !clk_detect && !osc_enable)
      else $error("detector not low after external edge");

   osc_selected_a: assert property (@(posedge clk) disable iff (!rstn) // R02
      gap_full_s |=> clk_detect && osc_enable)
      else $error("oscillator not selected after long gap");

   osc_quiet_a: assert property (@(posedge clk) disable iff (!rstn) // R01
      !clk_detect && !$past(clk_detect) |-> osc_cnt == '0 && !osc_tick)
      else $error("oscillator ticks while external clock present");

   slow_ratio_a: assert property (@(posedge clk) disable iff (!rstn) // R04
      boundary && !rate_q |-> tick_seen == (CONV_W+1)'(RATIO_SLOW_P - 1))
      else $error("slow result spacing wrong");

   fast_ratio_a: assert property (@(posedge clk) disable iff (!rstn) // R05
      boundary && rate_q |-> tick_seen == (CONV_W+1)'(RATIO_FAST_P - 1))
      else $error("fast result spacing wrong");

   mod_follows_a: assert property (@(posedge clk) disable iff (!rstn) // R07
      mod_tick |-> active_tick && mod_gap == (MOD_W+1)'(MOD_DIV - 1))
      else $error("modulator strobe off the active clock");

   power_down_n_hold_a: assert property (@(posedge clk) disable iff (!rstn) // R11
      !power_down_n [*2] |-> conv_cnt == '0 && !result_valid && !active_tick)
      else $error("conversion logic active in power-down");

   restart_zero_a: assert property (@(posedge clk) disable iff (!rstn) // R13
      $rose(power_down_n) |-> conv_cnt == '0 && settle_cnt == '0)
      else $error("count not from zero after power-down");

   rate_restart_a: assert property (@(posedge clk) disable iff (!rstn) // R14
      rate_flip_s |=> settle_cnt == '0 && rate_q == $past(rate_sel) && result_valid)
      else $error("rate change not applied at boundary");

   valid_pulse_a: assert property (@(posedge clk) disable iff (!rstn) // R13
      result_valid |=> !result_valid)
      else $error("result strobe longer than one cycle");

   code_hold_a: assert property (@(posedge clk) disable iff (!rstn) // R13
      !result_valid && power_down_n && $past(power_down_n) |-> $stable(result_code))
      else $error("result word changed between results");
endmodule

// [tb/acr_far_model.sv]
// far side model: external clock source and result collecting host
`timescale 1ns/1ps
module acr_far_model (
   input  wire logic       clk,
   input  wire logic       ext_run,
   input  wire logic [3:0] half,
   input  wire logic       result_valid,
   input  wire logic       result_settled,
   output logic            ext_clock_in,
   output int              n_res,
   output int              n_kept
);
   int ph = 0;
   initial ext_clock_in = 1'b0;
   initial n_res = 0;
   initial n_kept = 0;
   // clock source: toggles every half cycles, tied to ground when stopped
   always @(posedge clk) begin
      if (!ext_run) begin
         ext_clock_in <= #1 1'b0;
         ph <= 0;
      end else if (ph >= int'(half) - 1) begin
         ext_clock_in <= #1 ~ext_clock_in;
         ph <= 0;
      end else begin
         ph <= ph + 1;
      end
   end
   // host: counts results, keeps only settled readings
   always @(posedge clk) begin
      if (result_valid === 1'b1) begin
         n_res <= n_res + 1;
         if (result_settled === 1'b1) begin
            n_kept <= n_kept + 1;
         end
      end
   end
endmodule

// [tb/acr_rate_ctrl_bench.sv]
// self-checking bench for the clock and rate control block
`timescale 1ns/1ps
module acr_rate_ctrl_bench;
   import acr_pkg::*;
   localparam int SLOW = 640;
   localparam int FAST = 128;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic power_down_n = 1'b1;
   logic rate_sel = 1'b1;
   logic mod_bit = 1'b0;
   logic ext_run = 1'b0;
   logic [3:0] half = 4'h4;
   logic pos = 1'b0;
   logic ext_clock_in, clk_detect, osc_enable, active_tick, mod_tick;
   logic result_valid, result_settled;
   logic [CODE_W-1:0] result_code;
   logic [31:0] seed = 32'h0000_28ea;
   int n_res, n_kept, err_total = 0, checked = 0, cyc = 0;
   time tp = 0, tn = 0;
   int gap = 0;
   int n_act = 0, n_mod = 0, g_act = 0, g_mod = 0;

   always #4 clk = ~clk;

   acr_rate_ctrl #(.RATIO_SLOW_P(SLOW), .RATIO_FAST_P(FAST)) i_acr_rate_ctrl (
      .clk(clk), .rstn(rstn), .ext_clock_in(ext_clock_in), .power_down_n(power_down_n),
      .rate_sel(rate_sel), .mod_bit(mod_bit), .clk_detect(clk_detect),
      .osc_enable(osc_enable), .active_tick(active_tick), .mod_tick(mod_tick),
      .result_code(result_code), .result_valid(result_valid),
      .result_settled(result_settled));

   acr_far_model i_acr_far_model (
      .clk(clk), .ext_run(ext_run), .half(half), .result_valid(result_valid),
      .result_settled(result_settled), .ext_clock_in(ext_clock_in), .n_res(n_res),
      .n_kept(n_kept));

   // xorshift source for repeatable random stimulus
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   // modulator bit stream: random, or all ones for a positive input
   always @(posedge clk) begin
      seed = xs(seed);
      mod_bit <= #1 pos | seed[0];
   end

   // counts active clock and modulator strobes between results
   always @(posedge clk) begin
      if (active_tick === 1'b1) n_act++;
      if (mod_tick === 1'b1) n_mod++;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   // waits for the next result pulse and measures the spacing in clocks
   task automatic next_res();
      do begin
         @(posedge clk);
         #2;
      end while (result_valid !== 1'b1);
      tn = $time;
      gap = int'((tn - tp) / 8);
      tp = tn;
      g_act = n_act;
      g_mod = n_mod;
      n_act = 0;
      n_mod = 0;
   endtask

   task automatic results();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // run limit: all scenarios need well under this many cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         err_total++;
         results();
      end
   end

   initial begin
      repeat (16) @(posedge clk);
      #1 rstn = 1'b1;
      power_down_n = 1'b0;
      repeat (3) @(posedge clk);
      #2 chk("clk_detect", 1, clk_detect);
      chk("osc_enable", 1, osc_enable);
      // power-down held past a full fast interval gives no result
      repeat (4000) @(posedge clk);
      #2 chk("n_res", 0, n_res);
      @(posedge clk);
      #1 power_down_n = 1'b1;
      pos = 1'b1;
      // oscillator, fast rate: spacing and settling count
      for (int k = 1; k <= 7; k++) begin
         next_res();
         chk("settled", (k >= 5), result_settled);
         if (k > 1) chk("gap", FAST * OSC_DIV, gap);
         if (k > 1) chk("active_tick", FAST, g_act);
         if (k > 1) chk("mod_tick", FAST / MOD_DIV, g_mod);
      end
      chk("code_sign", 0, result_code[CODE_W-1]);
      @(posedge clk);
      #1 pos = 1'b0;
      rate_sel = 1'b0;
      next_res();
      chk("gap", FAST * OSC_DIV, gap);
      chk("n_res", 7, n_res);
      chk("n_kept", 3, n_kept);
      next_res();
      chk("gap", SLOW * OSC_DIV, gap);
      chk("settled", 0, result_settled);
      // external clock with a random half period
      seed = xs(seed);
      @(posedge clk);
      #1 half = 4'(3 + seed[1:0]);
      ext_run = 1'b1;
      rate_sel = 1'b1;
      repeat (4 * int'(half) + 6) @(posedge clk);
      #2 chk("clk_detect", 0, clk_detect);
      chk("osc_enable", 0, osc_enable);
      repeat (3) next_res();
      chk("gap", FAST * 2 * int'(half), gap);
      chk("active_tick", FAST, g_act);
      chk("mod_tick", FAST / MOD_DIV, g_mod);
      // external clock stopped: back to the oscillator
      @(posedge clk);
      #1 ext_run = 1'b0;
      repeat (DET_CYCLES + 60) @(posedge clk);
      #2 chk("clk_detect", 1, clk_detect);
      chk("osc_enable", 1, osc_enable);
      results();
   end
endmodule
